// File: pkg/alu_consts.vh
// Purpose: Constants for the byte ALU with multiplier.
// Assumes: Included by bare name from design files.
// Notes: Operation codes are the encoding of the op port.
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH
`define OP_W            5
`define OP_SUM          5'h00
`define OP_CARRY_SUM    5'h01
`define OP_WORD_PLUS    5'h02
`define OP_DIFF         5'h03
`define OP_DIFF_IMM     5'h04
`define OP_BORROW       5'h05
`define OP_BORROW_IMM   5'h06
`define OP_WORD_MINUS   5'h07
`define OP_AND          5'h08
`define OP_AND_IMM      5'h09
`define OP_OR           5'h0A
`define OP_OR_IMM       5'h0B
`define OP_XOR          5'h0C
`define OP_ONES_INV     5'h0D
`define OP_TWOS_INV     5'h0E
`define OP_SET_BITS     5'h0F
`define OP_CLR_BITS     5'h10
`define OP_PLUS_ONE     5'h11
`define OP_MINUS_ONE    5'h12
`define OP_TEST         5'h13
`define OP_ZERO_REG     5'h14
`define OP_ALL_ONES     5'h15
`define OP_MUL_U        5'h16
`define OP_MUL_S        5'h17
`define OP_MUL_SU       5'h18
`define OP_FRAC_U       5'h19
`define OP_FRAC_S       5'h1A
`define OP_FRAC_SU      5'h1B
`define ALL_ONES_BYTE   8'hFF
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4
`define FLAG_H          5
`define FLAGS_W         6
`define FLAGS_RESET     6'h00
`define SINGLE_CYCLES   1
`define DOUBLE_CYCLES   2
`endif

// File: src/byte_adder.v
// Purpose: Eight-bit add or subtract with carry-in, giving carry and half-carry.
// Assumes: Purely combinational; sub selects subtraction with borrow.
// Notes: Carry out is a borrow when subtracting.
`timescale 1ns/1ps
`default_nettype none
module byte_adder
(
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       cin,
    input  wire       sub,
    output wire [7:0] sum,
    output wire       cout,
    output wire       half,
    output wire       ovf
);
    wire [7:0] b_eff;
    wire [8:0] full;
    wire [4:0] low;
    assign b_eff = sub ? ~b : b;
    // Subtraction is a + ~b + ~borrow, so borrow flags are inverted carries.
    assign full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, (cin ^ sub)};
    assign low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (cin ^ sub)};
    assign sum   = full[7:0];
    assign cout  = full[8] ^ sub;
    assign half  = low[4] ^ sub;
    assign ovf   = (a[7] == b_eff[7]) && (sum[7] != a[7]);
endmodule // byte_adder
`default_nettype wire

// File: src/byte_multiplier.v
// Purpose: Registered 8x8 multiplier with signed, unsigned and mixed modes.
// Assumes: Operands stable when start pulses.
// Notes: Product is available one cycle after start.
`timescale 1ns/1ps
`default_nettype none
module byte_multiplier
(
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire [7:0]  a,
    input  wire [7:0]  b,
    input  wire        a_signed,
    input  wire        b_signed,
    output reg  [15:0] product_q
);
    wire signed [8:0]  a_ext;
    wire signed [8:0]  b_ext;
    wire signed [17:0] full;
    assign a_ext = {a_signed & a[7], a};
    assign b_ext = {b_signed & b[7], b};
    assign full  = a_ext * b_ext;
    always @(posedge clk)
    begin
        if (rst)
            product_q <= 16'h0000;
        else if (start)
            product_q <= full[15:0];
    end
endmodule // byte_multiplier
`default_nettype wire

// File: src/byte_alu.v
// Purpose: Byte and word ALU datapath with multiplier and status flags.
// Assumes: Decoder presents op, operands and flags in the start cycle only.
// Notes: Result, write enables and flags are registered outputs.
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.vh"

module byte_alu
(
    input  wire                  clk,
    input  wire                  rst,
    input  wire                  start,
    input  wire [`OP_W-1:0]      op,
    input  wire [7:0]            dest,
    input  wire [7:0]            src,
    input  wire [7:0]            imm,
    input  wire [7:0]            pair_high,
    input  wire [7:0]            pair_low,
    input  wire [`FLAGS_W-1:0]   flags_in,
    output reg  [7:0]            result_low_q,
    output reg  [7:0]            result_high_q,
    output reg                   write_low_q,
    output reg                   write_pair_q,
    output reg                   product_pair_q,
    output reg  [`FLAGS_W-1:0]   flags_q,
    output reg                   flags_write_q,
    output reg                   busy_q,
    output reg                   done_q
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WORD = 3'b010;
    localparam ST_MUL  = 3'b100;

    reg  [2:0]            state_q;
    reg  [2:0]            state_d;
    reg  [`OP_W-1:0]      op_q;
    reg  [15:0]           word_sum_q;
    reg                   word_carry_q;
    reg                   word_ovf_q;
    reg  [7:0]            a_in;
    reg  [7:0]            b_in;
    reg                   cin;
    reg                   sub;
    reg  [7:0]            res;
    reg  [`FLAGS_W-1:0]   fl;
    reg                   wr;
    reg                   fwr;
    reg  [16:0]           word_calc;
    reg  [15:0]           prod_out;
    reg  [15:0]           word_res;
    wire [7:0]            add_sum;
    wire                  add_cout;
    wire                  add_half;
    wire                  add_ovf;
    wire [15:0]           product;
    wire                  mul_start;
    wire                  a_sg;
    wire                  b_sg;

    // Logic flags: V cleared, N from top bit, Z on zero, S follows N xor V.
    function [`FLAGS_W-1:0] logic_flags;
        input [7:0]          r;
        input [`FLAGS_W-1:0] old;
        begin
            logic_flags            = old;
            logic_flags[`FLAG_Z]   = (r == 8'h00);
            logic_flags[`FLAG_N]   = r[7];
            logic_flags[`FLAG_V]   = 1'b0;
            logic_flags[`FLAG_S]   = r[7];
        end
    endfunction

    function is_mul;
        input [`OP_W-1:0] o;
        begin
            is_mul = (o >= `OP_MUL_U) && (o <= `OP_FRAC_SU);
        end
    endfunction

    byte_adder u_adder
    (
        .a    (a_in),
        .b    (b_in),
        .cin  (cin),
        .sub  (sub),
        .sum  (add_sum),
        .cout (add_cout),
        .half (add_half),
        .ovf  (add_ovf)
    );

    assign mul_start = start && !busy_q && is_mul(op);
    assign a_sg = (op == `OP_MUL_S) || (op == `OP_MUL_SU) ||
                  (op == `OP_FRAC_S) || (op == `OP_FRAC_SU);
    assign b_sg = (op == `OP_MUL_S) || (op == `OP_FRAC_S);

    byte_multiplier u_mul
    (
        .clk       (clk),
        .rst       (rst),
        .start     (mul_start),
        .a         (dest),
        .b         (src),
        .a_signed  (a_sg),
        .b_signed  (b_sg),
        .product_q (product)
    );

    // Single-cycle byte path.
    always @*
    begin
        a_in = dest;
        b_in = src;
        cin  = 1'b0;
        sub  = 1'b0;
        res  = add_sum;
        fl   = flags_in;
        wr   = 1'b1;
        fwr  = 1'b1;
        case (op)
            `OP_SUM, `OP_CARRY_SUM:
            begin
                cin = (op == `OP_CARRY_SUM) & flags_in[`FLAG_C];
            end
            `OP_DIFF, `OP_DIFF_IMM, `OP_BORROW, `OP_BORROW_IMM:
            begin
                sub  = 1'b1;
                b_in = ((op == `OP_DIFF_IMM) || (op == `OP_BORROW_IMM)) ? imm : src;
                cin  = ((op == `OP_BORROW) || (op == `OP_BORROW_IMM)) &
                       flags_in[`FLAG_C];
            end
            `OP_TWOS_INV:
            begin
                sub  = 1'b1;
                a_in = 8'h00;
                b_in = dest;
            end
            `OP_ONES_INV:
            begin
                sub  = 1'b1;
                a_in = `ALL_ONES_BYTE;
                b_in = dest;
            end
            `OP_PLUS_ONE:
                b_in = 8'h01;
            `OP_MINUS_ONE:
            begin
                sub  = 1'b1;
                b_in = 8'h01;
            end
            default:
                b_in = src;
        endcase
        case (op)
            `OP_SUM, `OP_CARRY_SUM, `OP_DIFF, `OP_DIFF_IMM, `OP_TWOS_INV:
            begin
                fl[`FLAG_Z] = (add_sum == 8'h00);
                fl[`FLAG_C] = add_cout;
                fl[`FLAG_N] = add_sum[7];
                fl[`FLAG_V] = add_ovf;
                fl[`FLAG_S] = add_sum[7] ^ add_ovf;
                fl[`FLAG_H] = add_half;
            end
            `OP_BORROW, `OP_BORROW_IMM:
            begin
                // Zero only stays set across a borrow chain.
                fl[`FLAG_Z] = (add_sum == 8'h00) & flags_in[`FLAG_Z];
                fl[`FLAG_C] = add_cout;
                fl[`FLAG_N] = add_sum[7];
                fl[`FLAG_V] = add_ovf;
                fl[`FLAG_S] = add_sum[7] ^ add_ovf;
                fl[`FLAG_H] = add_half;
            end
            `OP_ONES_INV:
            begin
                fl = logic_flags(add_sum, flags_in);
                fl[`FLAG_C] = 1'b1;
            end
            `OP_PLUS_ONE, `OP_MINUS_ONE:
            begin
                fl = logic_flags(add_sum, flags_in);
                fl[`FLAG_V] = add_ovf;
                fl[`FLAG_S] = add_sum[7] ^ add_ovf;
            end
            `OP_AND, `OP_AND_IMM, `OP_TEST:
            begin
                res = dest & ((op == `OP_AND_IMM) ? imm : ((op == `OP_TEST) ? dest : src));
                fl  = logic_flags(res, flags_in);
            end
            `OP_OR, `OP_OR_IMM, `OP_SET_BITS:
            begin
                res = dest | ((op == `OP_OR) ? src : imm);
                fl  = logic_flags(res, flags_in);
            end
            `OP_XOR, `OP_ZERO_REG:
            begin
                res = dest ^ ((op == `OP_XOR) ? src : dest);
                fl  = logic_flags(res, flags_in);
            end
            `OP_CLR_BITS:
            begin
                res = dest & (`ALL_ONES_BYTE ^ imm);
                fl  = logic_flags(res, flags_in);
            end
            `OP_ALL_ONES:
            begin
                res = `ALL_ONES_BYTE;
                fwr = 1'b0;
            end
            default:
            begin
                wr  = 1'b0;
                fwr = 1'b0;
            end
        endcase
    end

    // Word operations on the pair; first cycle computes, second writes.
    always @*
    begin
        if (op == `OP_WORD_MINUS)
            word_calc = {1'b0, pair_high, pair_low} - {9'h000, imm};
        else
            word_calc = {1'b0, pair_high, pair_low} + {9'h000, imm};
    end

    always @*
    begin
        prod_out = product;
        if (op_q >= `OP_FRAC_U)
            prod_out = {product[14:0], 1'b0};
    end

    always @*
    begin
        word_res = (state_q == ST_MUL) ? prod_out : word_sum_q;
        state_d  = ST_IDLE;
        case (state_q)
            ST_IDLE:
            begin
                if (start && (op == `OP_WORD_PLUS || op == `OP_WORD_MINUS))
                    state_d = ST_WORD;
                else if (start && is_mul(op))
                    state_d = ST_MUL;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_q        <= ST_IDLE;
            op_q           <= `OP_SUM;
            word_sum_q     <= 16'h0000;
            word_carry_q   <= 1'b0;
            word_ovf_q     <= 1'b0;
            result_low_q   <= 8'h00;
            result_high_q  <= 8'h00;
            write_low_q    <= 1'b0;
            write_pair_q   <= 1'b0;
            product_pair_q <= 1'b0;
            flags_q        <= `FLAGS_RESET;
            flags_write_q  <= 1'b0;
            busy_q         <= 1'b0;
            done_q         <= 1'b0;
        end
        else
        begin
            state_q        <= state_d;
            write_low_q    <= 1'b0;
            write_pair_q   <= 1'b0;
            product_pair_q <= 1'b0;
            flags_write_q  <= 1'b0;
            done_q         <= 1'b0;
            busy_q         <= (state_d != ST_IDLE);
            if (state_q == ST_IDLE && start)
            begin
                op_q         <= op;
                word_sum_q   <= word_calc[15:0];
                word_carry_q <= word_calc[16];
                word_ovf_q   <= (op == `OP_WORD_MINUS) ?
                                (pair_high[7] & ~word_calc[15]) :
                                (~pair_high[7] & word_calc[15]);
                if (state_d == ST_IDLE)
                begin
                    result_low_q  <= res;
                    write_low_q   <= wr;
                    flags_q       <= fl;
                    flags_write_q <= fwr;
                    done_q        <= 1'b1;
                end
                else
                    flags_q       <= flags_in;
            end
            else if (state_q != ST_IDLE)
            begin
                result_low_q   <= word_res[7:0];
                result_high_q  <= word_res[15:8];
                write_pair_q   <= 1'b1;
                product_pair_q <= (state_q == ST_MUL);
                flags_write_q  <= 1'b1;
                done_q         <= 1'b1;
                flags_q[`FLAG_Z] <= (word_res == 16'h0000);
                if (state_q == ST_MUL)
                    flags_q[`FLAG_C] <= product[15];
                else
                begin
                    flags_q[`FLAG_C] <= word_carry_q;
                    flags_q[`FLAG_N] <= word_sum_q[15];
                    flags_q[`FLAG_V] <= word_ovf_q;
                    flags_q[`FLAG_S] <= word_sum_q[15] ^ word_ovf_q;
                end
            end
        end
    end
endmodule // byte_alu
`default_nettype wire

// File: bench/alu_checker.sv
// Purpose: Port checks of ALU timing, results and flags.
// Assumes: Sees only top ports; op codes from alu_consts.vh.
// Notes: Borrow ops chain the zero flag, so they skip the byte zero check.
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.vh"
module alu_checker
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                start,
    input wire logic [`OP_W-1:0]    op,
    input wire logic [7:0]          dest,
    input wire logic [7:0]          src,
    input wire logic [7:0]          imm,
    input wire logic [7:0]          result_low_q,
    input wire logic [7:0]          result_high_q,
    input wire logic                write_low_q,
    input wire logic                write_pair_q,
    input wire logic                product_pair_q,
    input wire logic [`FLAGS_W-1:0] flags_q,
    input wire logic                flags_write_q,
    input wire logic                busy_q,
    input wire logic                done_q
);
    logic take;
    logic two;
    logic mul;
    assign take = start && !busy_q;
    assign mul = (op >= `OP_MUL_U) && (op <= `OP_FRAC_SU);
    assign two = mul || (op == `OP_WORD_PLUS) || (op == `OP_WORD_MINUS);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_one_cycle: assert property (take && !two |=> done_q && !busy_q)
        else $error("single op not done in one cycle");
    a_two_cycle: assert property (take && two |=> busy_q && !done_q ##1 done_q && !busy_q)
        else $error("double op timing wrong");
    a_sum_value: assert property (take && op == `OP_SUM |=>
        write_low_q && result_low_q == $past(dest) + $past(src))
        else $error("sum result wrong");
    a_diff_value: assert property (take && op == `OP_DIFF_IMM |=>
        result_low_q == $past(dest) - $past(imm))
        else $error("difference result wrong");
    a_logic_flags: assert property (take && (op == `OP_AND || op == `OP_XOR) |=>
        !flags_q[`FLAG_V] && flags_q[`FLAG_Z] == (result_low_q == 8'h00))
        else $error("logic flags wrong");
    a_ones_no_flag: assert property (take && op == `OP_ALL_ONES |=>
        result_low_q == 8'hFF && write_low_q && !flags_write_q)
        else $error("all ones load wrong");
    a_product_pair: assert property (take && mul |=> ##1
        write_pair_q && product_pair_q && !write_low_q)
        else $error("product not to product pair");
    a_frac_shift: assert property (take && op == `OP_FRAC_U |=> ##1
        {result_high_q, result_low_q} == ($past(dest, 2) * $past(src, 2)) << 1)
        else $error("fractional product wrong");
    a_word_sign: assert property (write_pair_q && !product_pair_q |->
        flags_q[`FLAG_S] == (flags_q[`FLAG_N] ^ flags_q[`FLAG_V]))
        else $error("word sign flag wrong");
    a_byte_flags: assert property (write_low_q && flags_write_q
        && $past(op) != `OP_BORROW && $past(op) != `OP_BORROW_IMM |->
        flags_q[`FLAG_N] == result_low_q[7]
        && flags_q[`FLAG_Z] == (result_low_q == 8'h00))
        else $error("byte zero or negative flag wrong");
    c_word: cover property (take && two);
    c_borrow: cover property (take && op == `OP_BORROW);
    c_product: cover property (write_pair_q && product_pair_q);
endmodule // alu_checker
bind byte_alu alu_checker i_chk (.clk, .rst, .start, .op, .dest, .src, .imm,
    .result_low_q, .result_high_q, .write_low_q, .write_pair_q, .product_pair_q,
    .flags_q, .flags_write_q, .busy_q, .done_q);
`default_nettype wire

// File: bench/reg_file_model.sv
// Purpose: Register file side: keeps written bytes, words and flags.
// Assumes: Write strobes are one-cycle pulses from the ALU.
// Notes: The bench preloads flags here, never in a write cycle.
`timescale 1ns/1ps
`default_nettype none
module reg_file_model
(
    input  wire logic       clk,
    input  wire logic       load,
    input  wire logic [5:0] load_val,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    input  wire logic       wr_lo,
    input  wire logic       wr_pair,
    input  wire logic       wr_prod,
    input  wire logic [5:0] fl,
    input  wire logic       wr_fl,
    output var  logic [7:0] byte_q,
    output var  logic [15:0] word_q,
    output var  logic [15:0] prod_q,
    output var  logic [5:0] sreg_q
);
    always @(posedge clk)
    begin
        if (wr_lo) byte_q <= lo;
        if (wr_pair && !wr_prod) word_q <= {hi, lo};
        if (wr_pair && wr_prod) prod_q <= {hi, lo};
        if (load) sreg_q <= load_val;
        else if (wr_fl) sreg_q <= fl;
    end
endmodule // reg_file_model
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Directed tests of the byte ALU through its op protocol.
// Assumes: Flags are preloaded in the model one cycle before each op launched by run.
// Notes: Byte flag checks are masked per op; word and product checks compare all six flags.
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.vh"
module tb_top;
    logic clk, rst, start, load, wl, wp, pp, fw, busy, done;
    logic [`OP_W-1:0] op, o;
    logic [7:0]       dest, src, imm, ph, pl, rl, rh, byte_q;
    logic [5:0]       lval, fq, sreg;
    logic [15:0]      word_q, prod_q, p;
    int               err_count, total_checks, lat, a, b;
    byte_alu i_dut (.clk(clk), .rst(rst), .start(start), .op(op), .dest(dest),
        .src(src), .imm(imm), .pair_high(ph), .pair_low(pl), .flags_in(sreg),
        .result_low_q(rl), .result_high_q(rh), .write_low_q(wl), .write_pair_q(wp),
        .product_pair_q(pp), .flags_q(fq), .flags_write_q(fw), .busy_q(busy),
        .done_q(done));
    reg_file_model i_rf (.clk(clk), .load(load), .load_val(lval), .lo(rl), .hi(rh),
        .wr_lo(wl), .wr_pair(wp), .wr_prod(pp), .fl(fq), .wr_fl(fw), .byte_q(byte_q),
        .word_q(word_q), .prod_q(prod_q), .sreg_q(sreg));
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic run(input logic [4:0] c, input logic [7:0] d, s, k, input logic [5:0] f);
        load = 1'b1;
        lval = f;
        @(posedge clk);
        #1;
        load = 1'b0;
        op = c;
        dest = d;
        src = s;
        imm = k;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        lat = 1;
        while (done !== 1'b1 && lat < 8)
        begin
            @(posedge clk);
            #1;
            lat++;
        end
        @(posedge clk);
        #1;
    endtask
    // Byte op: result, flags under mask m, and one-cycle latency.
    task automatic bc(input logic [4:0] c, input logic [7:0] d, s, k, r,
                      input logic [5:0] f, m, fe);
        run(c, d, s, k, f);
        check("byte", byte_q, r);
        check("flags", sreg & m, fe);
        check("clocks", 16'(lat), 16'h0001);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #20000;
        err_count++;
        conclude();
    end
    initial
    begin
        {rst, start, load, op, dest, src, imm, ph, pl, lval} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        bc(`OP_SUM, 8'h0F, 8'h01, 8'h00, 8'h10, 6'h00, 6'h2F, 6'h20);
        bc(`OP_CARRY_SUM, 8'hFF, 8'h00, 8'h00, 8'h00, 6'h01, 6'h2F, 6'h23);
        bc(`OP_DIFF, 8'h00, 8'h01, 8'h00, 8'hFF, 6'h00, 6'h2F, 6'h25);
        bc(`OP_DIFF_IMM, 8'h80, 8'h00, 8'h01, 8'h7F, 6'h00, 6'h2F, 6'h28);
        bc(`OP_BORROW, 8'h10, 8'h10, 8'h00, 8'hFF, 6'h01, 6'h2F, 6'h25);
        bc(`OP_BORROW_IMM, 8'h05, 8'h00, 8'h05, 8'h00, 6'h02, 6'h2F, 6'h02);
        bc(`OP_BORROW_IMM, 8'h05, 8'h00, 8'h05, 8'h00, 6'h00, 6'h2F, 6'h00);
        bc(`OP_ONES_INV, 8'hC3, 8'h00, 8'h00, 8'h3C, 6'h00, 6'h0F, 6'h01);
        bc(`OP_TWOS_INV, 8'h01, 8'h00, 8'h00, 8'hFF, 6'h00, 6'h2F, 6'h25);
        bc(`OP_PLUS_ONE, 8'h7F, 8'h00, 8'h00, 8'h80, 6'h00, 6'h0E, 6'h0C);
        bc(`OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7F, 6'h00, 6'h0E, 6'h08);
        bc(`OP_TEST, 8'hC3, 8'h00, 8'h00, 8'hC3, 6'h08, 6'h0E, 6'h04);
        bc(`OP_AND, 8'hC3, 8'hF0, 8'h00, 8'hC0, 6'h08, 6'h0E, 6'h04);
        bc(`OP_AND_IMM, 8'hC3, 8'h00, 8'h3C, 8'h00, 6'h08, 6'h0E, 6'h02);
        bc(`OP_OR, 8'hC3, 8'hF0, 8'h00, 8'hF3, 6'h08, 6'h0E, 6'h04);
        bc(`OP_OR_IMM, 8'h03, 8'h00, 8'h30, 8'h33, 6'h08, 6'h0E, 6'h00);
        bc(`OP_XOR, 8'hC3, 8'hF0, 8'h00, 8'h33, 6'h08, 6'h0E, 6'h00);
        bc(`OP_SET_BITS, 8'h43, 8'h00, 8'h3C, 8'h7F, 6'h08, 6'h0E, 6'h00);
        bc(`OP_CLR_BITS, 8'hC3, 8'h00, 8'hC3, 8'h00, 6'h08, 6'h0E, 6'h02);
        bc(`OP_ZERO_REG, 8'hC3, 8'h00, 8'h00, 8'h00, 6'h08, 6'h0E, 6'h02);
        bc(`OP_ALL_ONES, 8'h00, 8'h00, 8'h00, 8'hFF, 6'h2A, 6'h3F, 6'h2A);
        $display("byte tests done");
        ph = 8'h7F;
        pl = 8'hFF;
        run(`OP_WORD_PLUS, 8'h00, 8'h00, 8'h01, 6'h00);
        check("word sum", word_q, 16'h8000);
        check("word flags", sreg & 6'h3F, 6'h0C);
        check("word clocks", 16'(lat), 16'h0002);
        ph = 8'h00;
        pl = 8'h00;
        run(`OP_WORD_MINUS, 8'h00, 8'h00, 8'h01, 6'h00);
        check("word diff", word_q, 16'hFFFF);
        check("word diff flags", sreg & 6'h3F, 6'h15);
        check("word diff clocks", 16'(lat), 16'h0002);
        $display("word tests done");
        for (int i = 0; i < 6; i++)
        begin
            o = 5'(`OP_MUL_U + i);
            a = (o == `OP_MUL_U || o == `OP_FRAC_U) ? 128 : -128;
            b = (o == `OP_MUL_S || o == `OP_FRAC_S) ? -64 : 192;
            p = 16'(a * b);
            run(o, 8'h80, 8'hC0, 8'h00, 6'h00);
            check("product", prod_q, (o >= `OP_FRAC_U) ? p << 1 : p);
            check("product flags", sreg & 6'h3F, {4'h0, p == 16'h0000, p[15]});
            check("product clocks", 16'(lat), 16'h0002);
        end
        $display("product tests done");
        // A start held high through the busy cycle must not launch a second op.
        pl = 8'h10;
        op = `OP_WORD_PLUS;
        imm = 8'h01;
        start = 1'b1;
        @(posedge clk);
        #1;
        op = `OP_SUM;
        @(posedge clk);
        #1;
        start = 1'b0;
        check("busy done", done, 1'b1);
        @(posedge clk);
        #1;
        check("ignored start", done, 1'b0);
        check("word after busy", word_q, 16'h0011);
        $display("busy test done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
